// ### include/mode_pd_pkg.sv
// Constants for the control-mode strap and power-down block
package mode_pd_pkg;
  // Strap levels of the address pin as reported by the analog level detector
  typedef enum logic [2:0] {
    STRAP_GND,
    STRAP_WEAK_DOWN,
    STRAP_OPEN,
    STRAP_WEAK_UP,
    STRAP_SUPPLY
  } strap_level_e;

  localparam logic [6:0] ADDR_GND = 7'h34;
  localparam logic [6:0] ADDR_WEAK_DOWN = 7'h35;
  localparam logic [6:0] ADDR_OPEN = 7'h36;
  localparam logic [6:0] ADDR_WEAK_UP = 7'h37;
  localparam logic [6:0] ADDR_NONE = 7'h00;

  // Density-input select lives in control register 0x06, bit 0
  localparam logic [7:0] REG_SERIAL_MODE = 8'h06;
  localparam int DENSITY_SEL_BIT = 0;

  // Zero samples before auto power-down
  localparam int ZERO_RUN_LEN = 2048;
  localparam int ZERO_CNT_W = 12;

  // Volume ramp: full scale 8-bit volume, 00h is mute, one step per cycle
  localparam int VOL_W = 8;
  localparam logic [7:0] VOL_MUTE = 8'h00;

  // Power-down settle time after mute, in ns, and its cycle count at 5 ns
  localparam int CLK_PERIOD_NS = 5;
  localparam int PD_SETTLE_NS = 1000;
  localparam int PD_SETTLE_CYC = (PD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Input rates: serial 48 kHz, or standalone density 3 or 6 MHz
  typedef enum logic [1:0] {
    RATE_SERIAL_48K,
    RATE_DENSITY_3M,
    RATE_DENSITY_6M
  } input_rate_e;
endpackage

// ### logic/mode_pd_ctrl.sv
// Control-mode strap decode, standalone option straps and soft power-down sequencing
//
// How it works
// - Address strap levels ground, weak down, open, weak up give addresses 34h-37h.
// - Strap tied to output supply selects standalone mode with no bus address.
// - In two-wire mode the serial port defaults to I2S or TDM input.
// - Density select bit in register 06h switches port to 1-bit density input.
// - Standalone forces soft power-down to 0 and auto power-down enable to 1.
// - Standalone, clock strap low: I2S 48 kHz, data strap picks left or right.
// - Standalone, clock strap high: density 3 or 6 MHz, frame sync picks slot.
// - Soft power-down stops all but the control interface, which keeps answering.
// - Soft power-down ramps volume to mute before finishing the shutdown.
// - Overcurrent protection is provided, with a control that disables it.
// - Auto power-down after 2048 zero samples in serial audio mode, wake on first nonzero sample.
module mode_pd_ctrl
  import mode_pd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [2:0] addrStrap,
  input wire logic clkStrap,
  input wire logic dataStrap,
  input wire logic frameSyncPin,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic softPowerDownReg,
  input wire logic autoPowerDownEnReg,
  input wire logic [7:0] volumeSet,
  input wire logic sampleValid,
  input wire logic sampleZero,
  input wire logic overcurrentDetect,
  input wire logic overcurrentDisable,
  output logic standalone,
  output logic [6:0] busAddress,
  output logic densityMode,
  output logic [1:0] inputRate,
  output logic slotRight,
  output logic [7:0] volumeOut,
  output logic coreEnable,
  output logic controlEnable,
  output logic powerDownDone,
  output logic autoPowerDown,
  output logic overcurrentTrip
);

  //////////////////////////////////////////////////////////////////////////////
  // Three-flop synchronisers for pins; change counts when stages two and three agree

  logic [2:0] addrS1_ff, addrS2_ff, addrS3_ff, addrQ_ff;
  logic [2:0] nxt_addrQ;
  logic [2:0] pinS1_ff, pinS2_ff, pinS3_ff, pinQ_ff;
  logic [2:0] nxt_pinQ;

  always_comb
  begin
    nxt_addrQ = (addrS2_ff == addrS3_ff) ? addrS3_ff : addrQ_ff;
    nxt_pinQ = pinQ_ff;
    for (int i = 0; i < 3; i++)
    begin
      if (pinS2_ff[i] == pinS3_ff[i])
      begin
        nxt_pinQ[i] = pinS3_ff[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addrS1_ff <= 3'h0;
      addrS2_ff <= 3'h0;
      addrS3_ff <= 3'h0;
      addrQ_ff <= 3'h0;
      pinS1_ff <= 3'h0;
      pinS2_ff <= 3'h0;
      pinS3_ff <= 3'h0;
      pinQ_ff <= 3'h0;
    end
    else
    begin
      addrS1_ff <= addrStrap;
      addrS2_ff <= addrS1_ff;
      addrS3_ff <= addrS2_ff;
      addrQ_ff <= nxt_addrQ;
      pinS1_ff <= {frameSyncPin, dataStrap, clkStrap};
      pinS2_ff <= pinS1_ff;
      pinS3_ff <= pinS2_ff;
      pinQ_ff <= nxt_pinQ;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture; waits a few cycles after release so the synchronisers settle

  logic [2:0] settle_ff, nxt_settle;
  logic latched_ff, nxt_latched;
  logic standalone_ff, nxt_standalone;
  logic [6:0] busAddr_ff, nxt_busAddr;
  logic clkStrap_ff, nxt_clkStrap;
  logic dataStrap_ff, nxt_dataStrap;

  always_comb
  begin
    nxt_settle = settle_ff;
    nxt_latched = latched_ff;
    nxt_standalone = standalone_ff;
    nxt_busAddr = busAddr_ff;
    nxt_clkStrap = clkStrap_ff;
    nxt_dataStrap = dataStrap_ff;
    if (!latched_ff)
    begin
      if (settle_ff != 3'h7)
      begin
        nxt_settle = settle_ff + 3'h1;
      end
      else
      begin
        nxt_latched = 1'b1;
        nxt_clkStrap = pinQ_ff[0];
        nxt_dataStrap = pinQ_ff[1];
        nxt_standalone = 1'b0;
        unique case (addrQ_ff)
          STRAP_GND: nxt_busAddr = ADDR_GND;
          STRAP_WEAK_DOWN: nxt_busAddr = ADDR_WEAK_DOWN;
          STRAP_OPEN: nxt_busAddr = ADDR_OPEN;
          STRAP_WEAK_UP: nxt_busAddr = ADDR_WEAK_UP;
          default:
          begin
            // Supply level, or an illegal code, is taken as standalone
            nxt_standalone = 1'b1;
            nxt_busAddr = ADDR_NONE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      settle_ff <= 3'h0;
      latched_ff <= 1'b0;
      standalone_ff <= 1'b0;
      busAddr_ff <= ADDR_NONE;
      clkStrap_ff <= 1'b0;
      dataStrap_ff <= 1'b0;
    end
    else
    begin
      settle_ff <= nxt_settle;
      latched_ff <= nxt_latched;
      standalone_ff <= nxt_standalone;
      busAddr_ff <= nxt_busAddr;
      clkStrap_ff <= nxt_clkStrap;
      dataStrap_ff <= nxt_dataStrap;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial port mode, rate and slot selection

  logic densitySel_ff, nxt_densitySel;
  logic density_ff, nxt_density;
  logic [1:0] rate_ff, nxt_rate;
  logic slot_ff, nxt_slot;
  logic spd, apdEn;

  // Standalone mode overrides the register copies of the power-down controls
  assign spd = standalone_ff ? 1'b0 : softPowerDownReg;
  assign apdEn = standalone_ff ? 1'b1 : autoPowerDownEnReg;

  always_comb
  begin
    nxt_densitySel = densitySel_ff;
    if (regWrite && !standalone_ff && regAddr == REG_SERIAL_MODE)
    begin
      nxt_densitySel = regWdata[DENSITY_SEL_BIT];
    end
    nxt_density = 1'b0;
    nxt_rate = RATE_SERIAL_48K;
    nxt_slot = 1'b0;
    if (standalone_ff)
    begin
      if (!clkStrap_ff)
      begin
        nxt_rate = RATE_SERIAL_48K;
        nxt_slot = dataStrap_ff;
      end
      else
      begin
        nxt_density = 1'b1;
        nxt_rate = dataStrap_ff ? RATE_DENSITY_6M : RATE_DENSITY_3M;
        nxt_slot = pinQ_ff[2];
      end
    end
    else
    begin
      // Default is I2S/TDM; frame sync is expected held low in density mode
      nxt_density = densitySel_ff;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      densitySel_ff <= 1'b0;
      density_ff <= 1'b0;
      rate_ff <= RATE_SERIAL_48K;
      slot_ff <= 1'b0;
    end
    else
    begin
      densitySel_ff <= nxt_densitySel;
      density_ff <= nxt_density;
      rate_ff <= nxt_rate;
      slot_ff <= nxt_slot;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Soft power-down sequence: ramp to mute, settle, then core off

  typedef enum logic [1:0] {PD_RUN, PD_RAMP, PD_SETTLE, PD_OFF} pd_state_e;
  pd_state_e pd_ff, nxt_pd;
  logic [7:0] vol_ff, nxt_vol;
  logic [8:0] setCnt_ff, nxt_setCnt;
  logic core_ff, nxt_core;
  logic done_ff, nxt_done;

  always_comb
  begin
    nxt_pd = pd_ff;
    nxt_vol = vol_ff;
    nxt_setCnt = setCnt_ff;
    nxt_core = core_ff;
    nxt_done = 1'b0;
    unique case (pd_ff)
      PD_RUN:
      begin
        nxt_vol = volumeSet;
        nxt_core = 1'b1;
        if (spd)
        begin
          nxt_pd = PD_RAMP;
        end
      end
      PD_RAMP:
      begin
        // Step down one code a cycle so the output never jumps
        if (vol_ff == VOL_MUTE)
        begin
          nxt_pd = PD_SETTLE;
          nxt_setCnt = 9'(PD_SETTLE_CYC - 1);
        end
        else
        begin
          nxt_vol = vol_ff - 8'h01;
        end
      end
      PD_SETTLE:
      begin
        if (setCnt_ff == 9'h000)
        begin
          nxt_pd = PD_OFF;
          nxt_core = 1'b0;
        end
        else
        begin
          nxt_setCnt = setCnt_ff - 9'h001;
        end
      end
      PD_OFF:
      begin
        nxt_done = 1'b1; // Clocks may now stop
        if (!spd)
        begin
          nxt_pd = PD_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pd_ff <= PD_RUN;
      vol_ff <= VOL_MUTE;
      setCnt_ff <= 9'h000;
      core_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      pd_ff <= nxt_pd;
      vol_ff <= nxt_vol;
      setCnt_ff <= nxt_setCnt;
      core_ff <= nxt_core;
      done_ff <= nxt_done;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Auto power-down on a run of zero samples, serial audio mode only

  logic [11:0] zeroCnt_ff, nxt_zeroCnt;
  logic apd_ff, nxt_apd;
  logic oc_ff, nxt_oc;

  always_comb
  begin
    nxt_zeroCnt = zeroCnt_ff;
    nxt_apd = apd_ff;
    if (!apdEn || density_ff)
    begin
      nxt_zeroCnt = 12'h000;
      nxt_apd = 1'b0;
    end
    else if (sampleValid)
    begin
      if (!sampleZero)
      begin
        nxt_zeroCnt = 12'h000;
        nxt_apd = 1'b0;
      end
      else if (zeroCnt_ff == 12'(ZERO_RUN_LEN - 1))
      begin
        nxt_apd = 1'b1;
      end
      else
      begin
        nxt_zeroCnt = zeroCnt_ff + 12'h001;
      end
    end
    // Sticky trip; disable saves power by ignoring the detector
    nxt_oc = overcurrentDisable ? 1'b0 : (oc_ff | overcurrentDetect);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      zeroCnt_ff <= 12'h000;
      apd_ff <= 1'b0;
      oc_ff <= 1'b0;
    end
    else
    begin
      zeroCnt_ff <= nxt_zeroCnt;
      apd_ff <= nxt_apd;
      oc_ff <= nxt_oc;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flops; control port on once straps latch, kept on through power-down

  assign standalone = standalone_ff;
  assign busAddress = busAddr_ff;
  assign densityMode = density_ff;
  assign inputRate = rate_ff;
  assign slotRight = slot_ff;
  assign volumeOut = vol_ff;
  assign coreEnable = core_ff;
  assign controlEnable = latched_ff;
  assign powerDownDone = done_ff;
  assign autoPowerDown = apd_ff;
  assign overcurrentTrip = oc_ff;
endmodule

// ### sim/audio_src_model.sv
// Serial audio source model: bursts of samples, one per cycle
module audio_src_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [12:0] runLen,
  input wire logic zeroIn,
  output logic sampleValid,
  output logic sampleZero,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] left;
  logic zeroVal;
  ////////////////////////////////////////
  // Zero flag toggles while idle between bursts so nothing reads a stale value
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      left <= 13'h0000;
      zeroVal <= 1'b0;
      sampleValid <= 1'b0;
      sampleZero <= 1'b0;
    end
    else if (left != 13'h0000)
    begin
      left <= left - 13'h0001;
      sampleValid <= 1'b1;
      sampleZero <= zeroVal;
    end
    else
    begin
      sampleValid <= 1'b0;
      sampleZero <= ~sampleZero;
      if (start)
      begin
        left <= runLen;
        zeroVal <= zeroIn;
      end
    end
  assign busy = (left != 13'h0000) || sampleValid;
endmodule

// ### sim/mode_pd_ctrl_asserts.sv
// Checker for strap decode and power-down sequencing
module mode_pd_ctrl_asserts
  import mode_pd_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic softPowerDownReg,
  input wire logic sampleValid,
  input wire logic sampleZero,
  input wire logic overcurrentDisable,
  input wire logic standalone,
  input wire logic [6:0] busAddress,
  input wire logic densityMode,
  input wire logic [7:0] volumeOut,
  input wire logic coreEnable,
  input wire logic controlEnable,
  input wire logic powerDownDone,
  input wire logic autoPowerDown,
  input wire logic overcurrentTrip
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // Mode, address and power relations
  a_addr_none: assert property (standalone |-> busAddress == ADDR_NONE)
    else $error("address in standalone");
  a_addr_range: assert property (controlEnable && !standalone |-> busAddress inside {[ADDR_GND:ADDR_WEAK_UP]})
    else $error("address out of range");
  a_mode_hold: assert property ($past(controlEnable) && controlEnable |-> $stable(busAddress) && $stable(standalone))
    else $error("mode moved");
  a_density_wr: assert property (regWrite && regAddr == REG_SERIAL_MODE && controlEnable && !standalone
    |-> ##2 densityMode == $past(regWdata[DENSITY_SEL_BIT], 2))
    else $error("density select lost");
  a_ramp_mute: assert property ($fell(coreEnable) && softPowerDownReg |-> volumeOut == VOL_MUTE)
    else $error("core off before mute");
  a_done_state: assert property (powerDownDone |-> !coreEnable && controlEnable)
    else $error("bad power-down state");
  a_sa_no_pd: assert property (standalone |-> !powerDownDone)
    else $error("standalone powered down");
  a_auto_wake: assert property (autoPowerDown && sampleValid && !sampleZero |=> !autoPowerDown)
    else $error("no wake");
  a_trip_hold: assert property (overcurrentTrip && !overcurrentDisable |=> overcurrentTrip)
    else $error("trip dropped");
  a_trip_off: assert property (overcurrentDisable |=> !overcurrentTrip)
    else $error("trip while disabled");
endmodule

bind mode_pd_ctrl mode_pd_ctrl_asserts u_chk (.*);

// ### sim/tb_top.sv
// Testbench for the strap decode and power-down block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mode_pd_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, clkStrap = 1'b0, dataStrap = 1'b0, frameSyncPin = 1'b0, regWrite = 1'b0;
  logic softPowerDownReg = 1'b0, autoPowerDownEnReg = 1'b0, overcurrentDetect = 1'b0, overcurrentDisable = 1'b0;
  logic start = 1'b0, zeroIn = 1'b0;
  logic [2:0] addrStrap = 3'h0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, volumeSet = 8'h00, volumeOut;
  logic [12:0] runLen = 13'h0000;
  logic standalone, densityMode, slotRight, coreEnable, controlEnable, powerDownDone, autoPowerDown;
  logic overcurrentTrip, sampleValid, sampleZero, busy;
  logic [6:0] busAddress;
  logic [1:0] inputRate;
  int fail_count = 0, n_checks = 0, cyc = 0, k;
  mode_pd_ctrl u_dut (.*);
  audio_src_model u_src (.*);
  ////////////////////////////////////////
  initial forever #2.5 clk = ~clk;
  // Hang guard well above the expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      results();
    end
  end
  task results;
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Straps only count at reset release, so each setting needs a reset
  task rst(input logic [2:0] a, input logic c, input logic d, input logic f);
    @(posedge clk);
    addrStrap <= a;
    clkStrap <= c;
    dataStrap <= d;
    frameSyncPin <= f; // Frame sync level; picks the slot in standalone density mode
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (k = 0; k < 50 && controlEnable !== 1'b1; k++) @(posedge clk);
    tick(1);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
    tick(2);
  endtask
  task zeros(input int n, input logic z);
    @(posedge clk);
    start <= 1'b1;
    runLen <= n[12:0];
    zeroIn <= z;
    @(posedge clk);
    start <= 1'b0;
    #1;
    for (k = 0; k < 3000 && busy; k++) @(posedge clk);
    tick(2);
  endtask
  initial
  begin
    for (int a = 0; a < 4; a++)
    begin
      rst(a[2:0], 1'b0, 1'b0, 1'b0);
      chk(standalone, 8'h00);
      chk({1'b0, busAddress}, 8'h34 + a[7:0]);
    end
    @(posedge clk);
    addrStrap <= 3'h4;
    tick(20);
    chk({1'b0, busAddress}, 8'h37);
    chk(densityMode, 8'h00);
    wr(REG_SERIAL_MODE, 8'h01);
    chk(densityMode, 8'h01);
    wr(8'h07, 8'h00);
    chk(densityMode, 8'h01);
    wr(REG_SERIAL_MODE, 8'h00);
    chk(densityMode, 8'h00);
    $display("Test decode and density done");
    @(posedge clk);
    volumeSet <= 8'h10;
    softPowerDownReg <= 1'b1;
    for (k = 0; k < 400 && powerDownDone !== 1'b1; k++) @(posedge clk);
    tick(1);
    chk(k >= PD_SETTLE_CYC, 8'h01);
    chk(volumeOut, VOL_MUTE);
    chk({powerDownDone, coreEnable, controlEnable}, 8'h05);
    wr(REG_SERIAL_MODE, 8'h01);
    chk(densityMode, 8'h01);
    wr(REG_SERIAL_MODE, 8'h00);
    @(posedge clk);
    softPowerDownReg <= 1'b0; // Clock kept running until done
    tick(3);
    chk({powerDownDone, coreEnable}, 8'h01);
    @(posedge clk);
    autoPowerDownEnReg <= 1'b1;
    zeros(2047, 1'b1);
    chk(autoPowerDown, 8'h00);
    zeros(1, 1'b1);
    chk(autoPowerDown, 8'h01);
    zeros(1, 1'b0);
    chk(autoPowerDown, 8'h00);
    @(posedge clk);
    overcurrentDetect <= 1'b1;
    @(posedge clk);
    overcurrentDetect <= 1'b0;
    tick(4);
    chk(overcurrentTrip, 8'h01);
    @(posedge clk);
    overcurrentDisable <= 1'b1;
    overcurrentDetect <= 1'b1;
    tick(4);
    chk(overcurrentTrip, 8'h00);
    @(posedge clk);
    overcurrentDetect <= 1'b0;
    overcurrentDisable <= 1'b0;
    $display("Test power-down done");
    for (int i = 0; i < 8; i++)
    begin
      rst(3'h4, i[2], i[1], i[0]);
      chk({standalone, busAddress}, 8'h80);
      chk(inputRate, {6'h00, i[2] & i[1], i[2] & ~i[1]});
      chk(slotRight, i[2] ? i[0] : i[1]);
      chk(densityMode, i[2]);
    end
    rst(3'h4, 1'b0, 1'b0, 1'b0);
    @(posedge clk);
    softPowerDownReg <= 1'b1;
    autoPowerDownEnReg <= 1'b0;
    clkStrap <= 1'b1;
    wr(REG_SERIAL_MODE, 8'h01);
    chk(densityMode, 8'h00);
    zeros(2048, 1'b1);
    chk(autoPowerDown, 8'h01);
    chk({powerDownDone, coreEnable, inputRate}, 8'h04);
    $display("Test standalone done");
    results();
  end
endmodule
